// file: src/vdr_ctrl.sv
`timescale 1ns/100ps
module vdr_ctrl
    import vdr_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_WAIT_CYC
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // user request port
    input  wire logic                        reqValid,
    output logic                             reqReady,
    input  wire logic                        reqWrite,
    input  wire logic                        reqMasked,
    input  wire logic                        reqTransfer,
    input  wire logic                        reqToArray,
    input  wire logic [vdr_pkg::ADDR_W-1:0]  reqRow,
    input  wire logic [vdr_pkg::ADDR_W-1:0]  reqCol,
    input  wire logic [vdr_pkg::DATA_W-1:0]  reqMask,
    input  wire logic [vdr_pkg::DATA_W-1:0]  reqWdata,
    // read answer and init status
    output logic                             rdValid,
    output logic [vdr_pkg::DATA_W-1:0]       rdData,
    output logic                             initDone,
    // memory pins
    output logic                             rowStrobeN,
    output logic                             colStrobeN,
    output logic [vdr_pkg::ADDR_W-1:0]       addrOut,
    output logic                             mask_write_enable_n,
    output logic                             transfer_output_enable_n,
    input  wire logic [vdr_pkg::DATA_W-1:0]  mask_data_io_in,
    output logic [vdr_pkg::DATA_W-1:0]       mask_data_io_out,
    output logic                             mask_data_io_oe,
    output logic                             serial_shift_strobe
);

    // ==========================================================
    // state
    // ==========================================================
    vdr_state_type        state_q;
    logic [TIMER_W-1:0]   timer_q;
    logic [POWER_W-1:0]   powerCnt_q;
    logic [INIT_W-1:0]    initCbr_q;
    logic [INIT_W-1:0]    initXfer_q;
    logic [INIT_W-1:0]    initSas_q;
    logic [ADDR_W-1:0]    curRow_q;
    logic [DATA_W-1:0]    curMask_q;
    logic                 curWrite_q;
    logic                 curMasked_q;
    logic                 curXfer_q;
    logic                 refreshPending;
    logic                 refreshAck;
    logic                 timerDone;
    logic                 initBusy;
    logic                 pageOk;
    logic                 idleOk;
    logic                 accept;

    assign timerDone = (timer_q == '0);
    assign initBusy  = (initCbr_q != '0) || (initXfer_q != '0) || (initSas_q != '0) || (state_q == stPowerUp);
    assign initDone  = !initBusy;

    // a new request may join the open row only if the row-fall choices still fit
    assign pageOk = (state_q == stColEnd) && timerDone && !refreshPending && !initBusy &&
                    !curXfer_q && !reqTransfer && (reqRow == curRow_q) &&
                    (reqMasked == curMasked_q) && (!reqMasked || reqMask == curMask_q);
    assign idleOk   = (state_q == stIdle) && !refreshPending && !initBusy;
    assign reqReady = idleOk || pageOk;
    assign accept   = reqValid && reqReady;
    assign refreshAck = (state_q == stCbrLow) && timerDone;

    // ==========================================================
    // refresh timing
    // ==========================================================
    vdr_refresh_timer uRefresh (
        .clk     (clk),
        .rst     (rst),
        .enable  (!initBusy),
        .ack     (refreshAck),
        .pending (refreshPending)
    );

    // ==========================================================
    // power-up wait, kept apart since its count is long
    // ==========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powerCnt_q <= '0;
        end else if (state_q == stPowerUp) begin
            powerCnt_q <= powerCnt_q + POWER_W'(1);
        end
    end

    // ==========================================================
    // strobe sequencer: states, phase timer and pin drive
    // ==========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q                  <= stPowerUp;
            timer_q                  <= '0;
            initCbr_q                <= INIT_W'(INIT_CYCLES);
            initXfer_q               <= INIT_W'(INIT_CYCLES);
            initSas_q                <= INIT_W'(INIT_CYCLES);
            curRow_q                 <= '0;
            curMask_q                <= '0;
            curWrite_q               <= 1'b0;
            curMasked_q              <= 1'b0;
            curXfer_q                <= 1'b0;
            rowStrobeN               <= 1'b1;
            colStrobeN               <= 1'b1;
            addrOut                  <= '0;
            mask_write_enable_n      <= 1'b1;
            transfer_output_enable_n <= 1'b1;
            mask_data_io_out         <= '0;
            mask_data_io_oe          <= 1'b0;
            serial_shift_strobe      <= 1'b0;
        end else begin
            if (!timerDone) begin
                timer_q <= timer_q - TIMER_W'(1);
            end
            case (state_q)
                stPowerUp: begin
                    if (powerCnt_q == POWER_W'(POWERUP_CYCLES - 1)) begin
                        state_q <= stIdle;
                    end
                end
                stIdle: begin
                    if (initCbr_q != '0 || (!initBusy && refreshPending)) begin
                        // column falls first so the device uses its own row counter;
                        // row-only and hidden refresh are not issued, column-first covers both
                        colStrobeN      <= 1'b0;
                        mask_data_io_oe <= 1'b0;
                        timer_q         <= TIMER_W'(REF_SETUP_CYC - 1);
                        state_q         <= stCbrSetup;
                    end else if (initXfer_q != '0) begin
                        // dummy read transfers of row zero during start-up
                        addrOut                  <= '0;
                        rowStrobeN               <= 1'b0;
                        transfer_output_enable_n <= 1'b0;
                        mask_write_enable_n      <= 1'b1;
                        curXfer_q                <= 1'b1;
                        curWrite_q               <= 1'b0;
                        curMasked_q              <= 1'b0;
                        curRow_q                 <= '0;
                        timer_q                  <= TIMER_W'(ROW_HOLD_CYC - 1);
                        state_q                  <= stRowOpen;
                    end else if (initSas_q != '0) begin
                        serial_shift_strobe <= 1'b1;
                        timer_q             <= TIMER_W'(SAS_HIGH_CYC - 1);
                        state_q             <= stSasHigh;
                    end else if (accept) begin
                        addrOut                  <= reqRow;
                        rowStrobeN               <= 1'b0;
                        transfer_output_enable_n <= !reqTransfer;
                        // low at row fall: masked write, or transfer into the array
                        mask_write_enable_n      <= reqTransfer ? !reqToArray
                                                                : !(reqWrite && reqMasked);
                        mask_data_io_out         <= reqMask;
                        mask_data_io_oe          <= reqWrite && reqMasked && !reqTransfer;
                        curRow_q                 <= reqRow;
                        curMask_q                <= reqMask;
                        curWrite_q               <= reqWrite && !reqTransfer;
                        curMasked_q              <= reqWrite && reqMasked && !reqTransfer;
                        curXfer_q                <= reqTransfer;
                        timer_q                  <= TIMER_W'(ROW_HOLD_CYC - 1);
                        state_q                  <= stRowOpen;
                    end
                end
                stRowOpen: begin
                    if (timerDone) begin
                        // hold interval over: switch pins to column phase
                        addrOut <= curXfer_q ? (initBusy ? '0 : reqCol) : reqCol;
                        if (curXfer_q) begin
                            mask_data_io_oe <= 1'b0;
                        end else if (curWrite_q) begin
                            mask_write_enable_n      <= 1'b0;
                            transfer_output_enable_n <= 1'b1;
                            mask_data_io_out         <= reqWdata;
                            mask_data_io_oe          <= 1'b1;
                        end else begin
                            mask_write_enable_n      <= 1'b1;
                            transfer_output_enable_n <= 1'b0;
                            mask_data_io_oe          <= 1'b0;
                        end
                        state_q <= stColSetup;
                    end
                end
                stColSetup: begin
                    colStrobeN <= 1'b0;
                    timer_q    <= TIMER_W'(CAS_LOW_CYC - 1);
                    state_q    <= stColLow;
                end
                stColLow: begin
                    if (timerDone) begin
                        // raising the transfer line here also starts a pending transfer
                        colStrobeN               <= 1'b1;
                        transfer_output_enable_n <= 1'b1;
                        mask_write_enable_n      <= 1'b1;
                        mask_data_io_oe          <= 1'b0;
                        timer_q                  <= TIMER_W'(CAS_PRE_CYC - 1);
                        state_q                  <= stColEnd;
                    end
                end
                stColEnd: begin
                    if (timerDone) begin
                        if (accept) begin
                            addrOut <= reqCol;
                            if (curWrite_q != reqWrite || !reqWrite) begin
                                curWrite_q <= reqWrite;
                            end
                            if (reqWrite) begin
                                mask_write_enable_n <= 1'b0;
                                mask_data_io_out    <= reqWdata;
                                mask_data_io_oe     <= 1'b1;
                            end else begin
                                transfer_output_enable_n <= 1'b0;
                            end
                            state_q <= stColSetup;
                        end else begin
                            rowStrobeN <= 1'b1;
                            if (curXfer_q && initXfer_q != '0) begin
                                initXfer_q <= initXfer_q - INIT_W'(1);
                            end
                            curXfer_q <= 1'b0;
                            timer_q   <= TIMER_W'(RAS_PRE_CYC - 1);
                            state_q   <= stRasPre;
                        end
                    end
                end
                stRasPre: begin
                    if (timerDone) begin
                        state_q <= stIdle;
                    end
                end
                stCbrSetup: begin
                    if (timerDone) begin
                        rowStrobeN <= 1'b0;
                        timer_q    <= TIMER_W'(RAS_LOW_CYC - 1);
                        state_q    <= stCbrLow;
                    end
                end
                stCbrLow: begin
                    if (timerDone) begin
                        rowStrobeN <= 1'b1;
                        colStrobeN <= 1'b1;
                        if (initCbr_q != '0) begin
                            initCbr_q <= initCbr_q - INIT_W'(1);
                        end
                        timer_q <= TIMER_W'(RAS_PRE_CYC - 1);
                        state_q <= stRasPre;
                    end
                end
                stSasHigh: begin
                    if (timerDone) begin
                        serial_shift_strobe <= 1'b0;
                        timer_q             <= TIMER_W'(SAS_HIGH_CYC - 1);
                        state_q             <= stSasLow;
                    end
                end
                stSasLow: begin
                    if (timerDone) begin
                        initSas_q <= initSas_q - INIT_W'(1);
                        state_q   <= stIdle;
                    end
                end
                default: begin
                    state_q <= stIdle;
                end
            endcase
        end
    end

    // ==========================================================
    // read capture at the end of the column low phase
    // ==========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdValid <= 1'b0;
            rdData  <= '0;
        end else begin
            rdValid <= 1'b0;
            if (state_q == stColLow && timerDone && !curWrite_q && !curXfer_q) begin
                rdValid <= 1'b1;
                rdData  <= mask_data_io_in;
            end
        end
    end

endmodule

// file: src/vdr_pkg.sv
// ==========================================================
// shared constants for the video dram random-port controller
// ==========================================================
package vdr_pkg;

    // ==========================================================
    // widths
    // ==========================================================
    localparam int ADDR_W   = 8;    // multiplexed row/column address
    localparam int DATA_W   = 4;    // parallel data/mask pins
    localparam int TIMER_W  = 8;    // phase timer
    localparam int INIT_W   = 4;    // init step counters
    localparam int REFCNT_W = 12;   // refresh interval counter
    localparam int POWER_W  = 16;   // power-up wait counter

    // ==========================================================
    // clock and conversion of times to cycles
    // ==========================================================
    localparam int CLK_PERIOD_NS = 20;

    // least time: round up, never below one cycle
    function automatic int cyclesMin(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time: round down, never below one cycle
    function automatic int cyclesMax(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // ==========================================================
    // power-up and refresh figures
    // ==========================================================
    localparam int POWERUP_WAIT_US  = 200;
    localparam int POWERUP_WAIT_CYC = cyclesMin(POWERUP_WAIT_US * 1000);
    localparam int INIT_CYCLES      = 8;
    localparam int REFRESH_ROWS     = 256;
    localparam int REFRESH_PERIOD_MS = 4;
    localparam int REFRESH_INTERVAL_NS = REFRESH_PERIOD_MS * 1000000 / REFRESH_ROWS;
    localparam int REFRESH_INTERVAL_CYC = cyclesMax(REFRESH_INTERVAL_NS);

    // ==========================================================
    // strobe timing, in ns
    // ==========================================================
    localparam int ROW_HOLD_NS        = 45;  // row address, mask data and mode hold after row fall
    localparam int OE_SWITCH_HOLD_NS  = 15;  // output_enable_switch_hold
    localparam int REFRESH_SETUP_NS   = 30;  // refresh_setup_interval
    localparam int RAS_LOW_NS         = 120; // least row strobe low time
    localparam int CAS_LOW_NS         = 80;  // column strobe low, covers access time
    localparam int CAS_PRE_NS         = 40;  // column strobe precharge
    localparam int RAS_PRE_NS         = 100; // row strobe precharge
    localparam int SAS_HIGH_NS        = 20;  // serial strobe pulse width

    localparam int ROW_HOLD_CYC  = cyclesMin((ROW_HOLD_NS > OE_SWITCH_HOLD_NS) ? ROW_HOLD_NS : OE_SWITCH_HOLD_NS);
    localparam int REF_SETUP_CYC = cyclesMin(REFRESH_SETUP_NS);
    localparam int RAS_LOW_CYC   = cyclesMin(RAS_LOW_NS);
    localparam int CAS_LOW_CYC   = cyclesMin(CAS_LOW_NS);
    localparam int CAS_PRE_CYC   = cyclesMin(CAS_PRE_NS);
    localparam int RAS_PRE_CYC   = cyclesMin(RAS_PRE_NS);
    localparam int SAS_HIGH_CYC  = cyclesMin(SAS_HIGH_NS);

    // ==========================================================
    // controller states
    // ==========================================================
    typedef enum logic [3:0] {
        stPowerUp,
        stIdle,
        stRowOpen,
        stColSetup,
        stColLow,
        stColEnd,
        stRasPre,
        stCbrSetup,
        stCbrLow,
        stSasHigh,
        stSasLow
    } vdr_state_type;

endpackage

// file: src/vdr_refresh_timer.sv
`timescale 1ns/100ps
// ==========================================================
// refresh interval timer
// ==========================================================
module vdr_refresh_timer
    import vdr_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic enable,
    input  wire logic ack,
    output logic      pending
);

    logic [REFCNT_W-1:0] count_q;
    logic                pending_q;
    logic                tick;

    assign tick    = enable && (count_q == '0);
    assign pending = pending_q;

    // interval counter, held at its reload value while disabled and reloaded at each tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (!enable || tick) begin
            count_q <= REFCNT_W'(REFRESH_INTERVAL_CYC - 1);
        end else begin
            count_q <= count_q - REFCNT_W'(1);
        end
    end

    // a tick in the same cycle as the ack keeps the request alive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending_q <= 1'b0;
        end else if (tick) begin
            pending_q <= 1'b1;
        end else if (ack) begin
            pending_q <= 1'b0;
        end
    end

endmodule

// file: tb/vdr_ctrl_properties.sv
`timescale 1ns/100ps
// ==========================================================
// pin-level checker for the random-port controller
// ==========================================================
module vdr_ctrl_properties
    import vdr_pkg::*;
(
    // clock, reset, strobes and pins
    input wire logic                       clk, rst, reqReady, rdValid, initDone, rowStrobeN, colStrobeN,
    input wire logic                       mask_write_enable_n, transfer_output_enable_n, mask_data_io_oe,
    input wire logic [vdr_pkg::ADDR_W-1:0] addrOut,
    input wire logic [vdr_pkg::DATA_W-1:0] rdData, mask_data_io_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_init; !initDone |-> !reqReady; endproperty
    a_init: assert property (p_init) else $error("request taken before init");
    property p_row_addr; $fell(rowStrobeN) && colStrobeN |=> $stable(addrOut)[*2]; endproperty
    a_row_addr: assert property (p_row_addr) else $error("row address moved in hold");
    property p_col_addr; $fell(colStrobeN) && !rowStrobeN |-> $stable(addrOut); endproperty
    a_col_addr: assert property (p_col_addr) else $error("column address moved at strobe");
    property p_col_low; $fell(colStrobeN) && !rowStrobeN |-> !colStrobeN[*4] ##1 colStrobeN; endproperty
    a_col_low: assert property (p_col_low) else $error("column strobe width wrong");
    // a read is told from a transfer by the enable level six samples back
    property p_rd;
        $rose(colStrobeN) && !rowStrobeN && $past(transfer_output_enable_n, 6) && $past(mask_write_enable_n)
        |-> rdValid && rdData == $past(mask_data_io_in);
    endproperty
    a_rd: assert property (p_rd) else $error("read word not returned");
    property p_early; $fell(colStrobeN) && !mask_write_enable_n && transfer_output_enable_n |-> mask_data_io_oe;
    endproperty
    a_early: assert property (p_early) else $error("write data not driven");
    property p_masked; $fell(rowStrobeN) && !mask_write_enable_n && transfer_output_enable_n |-> mask_data_io_oe;
    endproperty
    a_masked: assert property (p_masked) else $error("mask not driven at row fall");
    property p_release; !rowStrobeN && !transfer_output_enable_n && mask_write_enable_n |-> !mask_data_io_oe;
    endproperty
    a_release: assert property (p_release) else $error("pins driven during read");
    property p_cbr; $fell(rowStrobeN) && !colStrobeN |-> !$past(colStrobeN, 2); endproperty
    a_cbr: assert property (p_cbr) else $error("refresh setup too short");
    property p_page; $rose(colStrobeN) && !rowStrobeN |-> !rowStrobeN[*2]; endproperty
    a_page: assert property (p_page) else $error("row closed too early");
endmodule
bind vdr_ctrl vdr_ctrl_properties vdr_ctrl_properties_inst (.clk, .rst, .reqReady, .rdValid, .initDone,
    .rowStrobeN, .colStrobeN, .mask_write_enable_n, .transfer_output_enable_n, .mask_data_io_oe, .addrOut,
    .rdData, .mask_data_io_in);

// file: tb/vdr_ctrl_test.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for the random-port controller
// ==========================================================
module vdr_ctrl_test;
    import vdr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, reqMasked = 1'b0, reqTransfer = 1'b0;
    logic reqToArray = 1'b0, reqReady, rdValid, initDone, rowStrobeN, colStrobeN, devOe, serial_shift_strobe;
    logic mask_write_enable_n, transfer_output_enable_n, mask_data_io_oe;
    logic [ADDR_W-1:0] reqRow = 8'h00, reqCol = 8'h00, addrOut;
    logic [DATA_W-1:0] reqMask = 4'h0, reqWdata = 4'h0, rdData, mask_data_io_out, devData, dq;
    logic [DATA_W-1:0] rdQ [$];
    int error_cnt = 0, samples_checked = 0, rowFalls = 0, sasPulses = 0;
    // an undriven wire wobbles each cycle so a stale word never passes as data
    assign dq = mask_data_io_oe ? mask_data_io_out : devOe ? devData : ({4{clk}} ^ 4'h5);
    vdr_ctrl #(.POWERUP_CYCLES(20)) vdr_ctrl_inst (.*, .mask_data_io_in(dq));
    vdr_dram_model vdr_dram_model_inst (.rowStrobeN, .colStrobeN, .meWeN(mask_write_enable_n),
        .trOeN(transfer_output_enable_n), .addr(addrOut), .dq, .devOe, .devData);
    initial forever #10 clk = ~clk;
    always @(negedge clk) if (rdValid === 1'b1) rdQ.push_back(rdData);
    always @(negedge rowStrobeN) rowFalls++;
    always @(posedge serial_shift_strobe) sasPulses++;
    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // kind is {write, masked, transfer, toArray}; fields stay put past the row hold
    task automatic req(input logic [3:0] kind, input logic [7:0] r, c, input logic [3:0] k, d);
        {reqWrite, reqMasked, reqTransfer, reqToArray, reqRow, reqCol, reqMask, reqWdata} = {kind, r, c, k, d};
        reqValid = 1'b1;
        #1;
        while (reqReady !== 1'b1) #20;
        @(negedge clk) reqValid = 1'b0;
        repeat (ROW_HOLD_CYC) @(negedge clk);
    endtask
    task automatic expect_rd(input logic [3:0] e);
        repeat (30) if (rdQ.size() == 0) @(negedge clk);
        chk(rdQ.size() > 0 ? rdQ.pop_front() : 4'hX, e);
    endtask
    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_write_read;
        req(4'h8, 8'hFF, 8'hFF, 4'h0, 4'h9);
        req(4'h8, 8'h00, 8'h01, 4'h0, 4'h6);
        req(4'h0, 8'hFF, 8'hFF, 4'h0, 4'h0);
        expect_rd(4'h9);
        req(4'h0, 8'h00, 8'h01, 4'h0, 4'h0);
        expect_rd(4'h6);
    endtask
    task automatic t_masked;
        req(4'h8, 8'h10, 8'h20, 4'h0, 4'hF);
        req(4'hC, 8'h10, 8'h20, 4'h5, 4'h0);
        req(4'h0, 8'h10, 8'h20, 4'h0, 4'h0);
        expect_rd(4'hA);
    endtask
    task automatic t_page;
        int f;
        req(4'h8, 8'h00, 8'h02, 4'h0, 4'h3);
        repeat (20) @(negedge clk);
        f = rowFalls;
        req(4'h0, 8'h00, 8'h01, 4'h0, 4'h0);
        req(4'h0, 8'h00, 8'h02, 4'h0, 4'h0);
        expect_rd(4'h6);
        expect_rd(4'h3);
        chk(8'(rowFalls - f), 8'h01);
    endtask
    task automatic t_refresh;
        logic [7:0] c0;
        c0 = vdr_dram_model_inst.refCnt;
        repeat (REFRESH_INTERVAL_CYC) @(negedge clk);
        chk(vdr_dram_model_inst.refCnt - c0, 8'h01);
    endtask
    task automatic t_transfer;
        for (int d = 0; d < 2; d++) begin
            req({3'b001, d[0]}, 8'h00, 8'h40, 4'h0, 4'h0);
            chk(vdr_dram_model_inst.toArrQ, d[0]);
            chk(vdr_dram_model_inst.xferQ, 1'b1);
        end
        repeat (12) @(negedge clk);
        chk(8'(rdQ.size()), 8'h00);
    endtask
    // ==========================================================
    // main sequence and watchdog
    // ==========================================================
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        while (initDone !== 1'b1) @(negedge clk);
        chk(vdr_dram_model_inst.refCnt, 8'h08);
        chk(8'(sasPulses), 8'h08);
        t_write_read();
        t_masked();
        t_page();
        t_refresh();
        t_transfer();
        end_of_test();
    end
    initial begin
        #(6000 * 20);
        error_cnt++;
        end_of_test();
    end
endmodule

// file: tb/vdr_dram_model.sv
`timescale 1ns/100ps
// ==========================================================
// behavioural random port of the video memory
// ==========================================================
module vdr_dram_model
    import vdr_pkg::*;
(
    // strobes, controls and pins
    input wire logic                       rowStrobeN, colStrobeN, meWeN, trOeN,
    input wire logic [vdr_pkg::ADDR_W-1:0] addr,
    input wire logic [vdr_pkg::DATA_W-1:0] dq,
    output logic                           devOe,
    output logic [vdr_pkg::DATA_W-1:0]     devData
);
    logic [DATA_W-1:0] mem [0:65535]; // row and column pick one word of four
    logic [ADDR_W-1:0] rowQ, colQ, refCnt = 8'h00;
    logic [DATA_W-1:0] maskQ;
    logic              xferQ, toArrQ, refQ, earlyQ = 1'b0;
    // row fall fixes the kind of cycle, the row, the mask and the refresh choice
    // the controller moves the row lines on the same edge as the strobe, so look once they have settled
    always @(negedge rowStrobeN) begin
        #1;
        rowQ = addr;
        xferQ = !trOeN;
        toArrQ = !meWeN;
        maskQ = meWeN ? 4'hF : dq;
        refQ = !colStrobeN;
        if (refQ) refCnt = refCnt + 8'h01;
    end
    // column fall picks the word; an early write lands here, masked bits keep old data
    always @(negedge colStrobeN) if (!rowStrobeN && !refQ && !xferQ) begin
        colQ = addr;
        earlyQ = !meWeN;
        if (earlyQ) mem[{rowQ, addr}] = (mem[{rowQ, addr}] & ~maskQ) | (dq & maskQ);
    end
    // drive only on a read with column strobe and trOeN low and meWeN high at column fall, never in refresh or transfer
    assign devOe = !colStrobeN && !trOeN && !earlyQ && !refQ && !xferQ;
    assign devData = mem[{rowQ, colQ}];
endmodule
